//--- hw/rsq_pkg.sv
package rsq_pkg;
    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] A_MDM2 = 8'h00;
    localparam logic [7:0] A_PKT1 = 8'h04;
    localparam logic [7:0] A_AGC0 = 8'h08;
    localparam logic [7:0] A_AGC1 = 8'h0c;
    localparam logic [7:0] A_AGC2 = 8'h10;
    localparam logic [7:0] A_PINO = 8'h14;
    localparam logic [7:0] A_RSSI = 8'h18;
    localparam logic [7:0] A_PSTS = 8'h1c;
    localparam logic [7:0] A_ISTS = 8'h20;
    localparam logic [7:0] A_ICLR = 8'h24;
    localparam logic [7:0] A_IEN = 8'h28;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int APP_BIT = 2;
    localparam int REL_LSB = 4;
    localparam int LNA_LSB = 3;
    localparam int DVGA_LSB = 6;
    localparam int PS_CS = 6;
    localparam int PS_SYNC = 3;
    localparam logic [2:0] MDM2_RST = 3'h2;
    localparam logic [3:0] ABS_RST = 4'h0;
    localparam logic [7:0] AGC2_RST = 8'h03;
    localparam logic [5:0] PINO_RST = 6'h2e;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // qualifier, rate and threshold constants
    // ************************************************************
    localparam logic [1:0] SM_NONE = 2'h0;
    localparam logic [1:0] SM_15_16 = 2'h1;
    localparam logic [1:0] SM_16_16 = 2'h2;
    localparam logic [4:0] TOL_16 = 5'h01;
    localparam logic [5:0] TOL_32 = 6'h02;
    localparam int RATE_DIV = 8;
    localparam int RATE_LOG2 = 3;
    localparam logic [5:0] CS_PIN_SEL = 6'h0e;
    localparam logic [3:0] ABS_DIS = 4'h8;
    localparam logic [2:0] MAGN_REF = 3'h7;
    localparam int MAGN_REF_DB = 42;
    localparam logic signed [9:0] THR_BASE = -10'sh021;
    localparam logic signed [9:0] LNA_STEP = 10'sh005;
    localparam logic signed [9:0] DVGA_STEP = 10'sh00c;
    localparam logic signed [9:0] MAGN_STEP = 10'sh004;
    localparam logic signed [9:0] HYST = 10'sh002;
    localparam logic signed [9:0] REL_6DB = 10'sh00c;
    localparam logic signed [9:0] REL_10DB = 10'sh014;
    localparam logic signed [9:0] REL_14DB = 10'sh01c;
    localparam int IRQ_W = 3;
endpackage

//--- hw/rsq_rate.sv
`timescale 1ns/1ps
module rsq_rate #(
    parameter int FLW = 2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    input wire logic filt_strobe,
    input wire logic [FLW-1:0] filt_len,
    output logic sample_en
);
    localparam int CW = rsq_pkg::RATE_LOG2 + (1 << FLW) - 1;

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] last;

    if (FLW < 1 || FLW > 3) begin : g_chk
        $error("rsq_rate: FLW must be 1 to 3");
    end

    // filter samples arrive at twice the channel bandwidth
    assign last = CW'((rsq_pkg::RATE_DIV << filt_len) - 1);

    always_ff @(posedge clk) begin
        if (srst || !run) begin
            cnt_r <= '0;
            sample_en <= 1'b0;
        end else begin
            sample_en <= filt_strobe && (cnt_r == last);
            if (filt_strobe) begin
                cnt_r <= (cnt_r == last) ? '0 : cnt_r + 1'b1;
            end
        end
    end
endmodule

//--- hw/rsq_cs.sv
`timescale 1ns/1ps
module rsq_cs (
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    input wire logic sample_en,
    input wire logic valid,
    input wire logic [7:0] rssi,
    input wire logic [2:0] lna,
    input wire logic [1:0] dvga,
    input wire logic [2:0] magn,
    input wire logic [3:0] abs_off,
    input wire logic [1:0] rel_step,
    output logic cs
);
    logic signed [9:0] cur;
    logic signed [9:0] thr;
    logic signed [9:0] stp;
    logic signed [9:0] prv_r;
    logic abs_r;
    logic rel_r;
    logic abs_on;
    logic rel_on;

    assign cur = $signed({{2{rssi[7]}}, rssi});
    // offset counts in 1 dB, i.e. two half-dB units
    assign thr = 10'(rsq_pkg::THR_BASE
        + 10'(lna) * rsq_pkg::LNA_STEP
        + 10'(dvga) * rsq_pkg::DVGA_STEP
        + (10'(magn) - 10'(rsq_pkg::MAGN_REF)) * rsq_pkg::MAGN_STEP
        + {{5{abs_off[3]}}, abs_off, 1'b0});
    assign abs_on = abs_off != rsq_pkg::ABS_DIS;
    assign rel_on = rel_step != 2'h0;
    assign stp = (rel_step == 2'h1) ? rsq_pkg::REL_6DB :
                 (rel_step == 2'h2) ? rsq_pkg::REL_10DB :
                 rsq_pkg::REL_14DB;

    always_ff @(posedge clk) begin
        if (srst || !run) begin
            abs_r <= 1'b0;
            rel_r <= 1'b0;
            prv_r <= '0;
            cs <= 1'b0;
        end else begin
            if (sample_en) begin
                prv_r <= cur;
                if (valid) begin
                    if (cur > thr) begin
                        abs_r <= 1'b1;
                    end else if (cur < thr - rsq_pkg::HYST) begin
                        abs_r <= 1'b0;
                    end
                    if (cur - prv_r >= stp) begin
                        rel_r <= 1'b1;
                    end else if (prv_r - cur >= stp) begin
                        rel_r <= 1'b0;
                    end
                end
            end
            cs <= (abs_on && abs_r) || (rel_on && rel_r);
        end
    end
endmodule

//--- hw/rsq_top.sv
`timescale 1ns/1ps
// Summary of operation
// - mode 000 no sync, 001 15/16, 010 16/16, 011 30/32 bits
// - modes 100-111 repeat 000-011 and also need carrier sense
// - with sync enabled, no fifo writes or filtering before sync
// - rssi tracks in receive until sync, then holds until re-entry; modes 000 and 100 never hold
// - rssi is two's complement in half-dB steps
// - rssi sample rate is filter rate over 8 times 2^length
// - appended first status byte carries last packet rssi
// - absolute mode: cs above threshold, drops below, with hysteresis
// - relative mode: cs on rise by step, off on fall by step
// - gated modes search sync only while cs is asserted
// - cs on output pin for select code 14, and in status bit
// - absolute offset shifts threshold by up to 7 dB, 1 dB steps
// - absolute offset resets to 0 dB
// - threshold derives from lna, digital gain, offset, target
// - magnitude target 111 means 42 dB at demodulator
// - cs also feeds clear-channel and fast termination logic
// - relative step disabled or 6, 10, 14 dB
module rsq_top #(
    parameter int AW = 8,
    parameter logic [5:0] PIN_SEL_RST = rsq_pkg::PINO_RST
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_mode,
    input wire logic filt_strobe,
    input wire logic [7:0] rssi_in,
    input wire logic bit_strobe,
    input wire logic [4:0] sync_err16,
    input wire logic [5:0] sync_err32,
    input wire logic [7:0] rx_byte,
    input wire logic rx_byte_valid,
    input wire logic packet_end,
    output logic sync_found,
    output logic filter_en,
    output logic fifo_wr_en,
    output logic [7:0] fifo_wr_data,
    output logic cs_cca,
    output logic cs_fast_term,
    output logic general_output_pin,
    output logic irq
);
    localparam int IW = rsq_pkg::IRQ_W;

    if (AW < 6 || AW > 32) begin : g_chk
        $error("rsq_top: AW must be 6 to 32");
    end

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic is_addr(input logic [AW-1:0] a,
                                     input logic [7:0] off);
        return a == AW'(off);
    endfunction

    function automatic logic sync_hit(input logic [1:0] m,
                                      input logic stb,
                                      input logic [4:0] e16,
                                      input logic [5:0] e32);
        logic r;
        r = 1'b0;
        case (m)
            rsq_pkg::SM_NONE: r = 1'b1;
            rsq_pkg::SM_15_16: r = stb && (e16 <= rsq_pkg::TOL_16);
            rsq_pkg::SM_16_16: r = stb && (e16 == 5'h00);
            default: r = stb && (e32 <= rsq_pkg::TOL_32);
        endcase
        return r;
    endfunction

    // ************************************************************
    // configuration and state
    // ************************************************************
    logic [2:0] mdm2_r;
    logic app_en_r;
    logic [1:0] flen_r;
    logic [1:0] rel_r;
    logic [3:0] absoff_r;
    logic [2:0] lna_r;
    logic [1:0] dvga_r;
    logic [2:0] magn_r;
    logic [5:0] pin_sel_r;
    logic [IW-1:0] irq_en_r;
    logic [IW-1:0] irq_sts_r;
    logic [IW-1:0] irq_sts_nxt;
    logic [IW-1:0] irq_clr;
    logic [IW-1:0] irq_ev;
    logic [7:0] rssi_r;
    logic [7:0] rssi_last_r;
    logic rssi_valid_r;
    logic rssi_hold_r;
    logic hold_set;
    logic rx_d_r;
    logic app_pend_r;
    logic rx_entry;
    logic sample_en;
    logic cs_int;
    logic hit;
    logic sync_set;
    logic sync_clr;
    logic wr_go;
    logic wr_do;
    logic rd_go;
    logic wr_bad;
    logic [31:0] rd_mux;
    logic rd_bad;
    logic [7:0] wb;

    // ************************************************************
    // axi4-lite slave
    // ************************************************************
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready
        && !s_axi_bvalid;
    assign wr_do = s_axi_awready;
    assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    assign wb = s_axi_wdata[7:0];
    assign wr_bad = !(is_addr(s_axi_awaddr, rsq_pkg::A_MDM2)
        || is_addr(s_axi_awaddr, rsq_pkg::A_PKT1)
        || is_addr(s_axi_awaddr, rsq_pkg::A_AGC0)
        || is_addr(s_axi_awaddr, rsq_pkg::A_AGC1)
        || is_addr(s_axi_awaddr, rsq_pkg::A_AGC2)
        || is_addr(s_axi_awaddr, rsq_pkg::A_PINO)
        || is_addr(s_axi_awaddr, rsq_pkg::A_RSSI)
        || is_addr(s_axi_awaddr, rsq_pkg::A_PSTS)
        || is_addr(s_axi_awaddr, rsq_pkg::A_ISTS)
        || is_addr(s_axi_awaddr, rsq_pkg::A_ICLR)
        || is_addr(s_axi_awaddr, rsq_pkg::A_IEN));

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_bad = 1'b0;
        if (is_addr(s_axi_araddr, rsq_pkg::A_MDM2)) begin
            rd_mux[2:0] = mdm2_r;
        end else if (is_addr(s_axi_araddr, rsq_pkg::A_PKT1)) begin
            rd_mux[rsq_pkg::APP_BIT] = app_en_r;
        end else if (is_addr(s_axi_araddr, rsq_pkg::A_AGC0)) begin
            rd_mux[1:0] = flen_r;
        end else if (is_addr(s_axi_araddr, rsq_pkg::A_AGC1)) begin
            rd_mux[7:0] = {2'h0, rel_r, absoff_r};
        end else if (is_addr(s_axi_araddr, rsq_pkg::A_AGC2)) begin
            rd_mux[7:0] = {dvga_r, lna_r, magn_r};
        end else if (is_addr(s_axi_araddr, rsq_pkg::A_PINO)) begin
            rd_mux[5:0] = pin_sel_r;
        end else if (is_addr(s_axi_araddr, rsq_pkg::A_RSSI)) begin
            rd_mux[7:0] = rssi_r;
        end else if (is_addr(s_axi_araddr, rsq_pkg::A_PSTS)) begin
            rd_mux[rsq_pkg::PS_CS] = cs_cca;
            rd_mux[rsq_pkg::PS_SYNC] = sync_found;
            rd_mux[0] = general_output_pin;
        end else if (is_addr(s_axi_araddr, rsq_pkg::A_ISTS)) begin
            rd_mux[IW-1:0] = irq_sts_r;
        end else if (is_addr(s_axi_araddr, rsq_pkg::A_IEN)) begin
            rd_mux[IW-1:0] = irq_en_r;
        end else if (!is_addr(s_axi_araddr, rsq_pkg::A_ICLR)) begin
            rd_bad = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rsq_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_bad ? rsq_pkg::RESP_SLVERR
                                      : rsq_pkg::RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= rsq_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= rd_go;
            if (s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_bad ? rsq_pkg::RESP_SLVERR
                                      : rsq_pkg::RESP_OKAY;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // only byte lane 0 carries register bits
    always_ff @(posedge clk) begin
        if (srst) begin
            mdm2_r <= rsq_pkg::MDM2_RST;
            app_en_r <= 1'b0;
            flen_r <= 2'h0;
            rel_r <= 2'h0;
            absoff_r <= rsq_pkg::ABS_RST;
            {dvga_r, lna_r, magn_r} <= rsq_pkg::AGC2_RST;
            pin_sel_r <= PIN_SEL_RST;
            irq_en_r <= '0;
        end else if (wr_do && s_axi_wstrb[0]) begin
            if (is_addr(s_axi_awaddr, rsq_pkg::A_MDM2)) begin
                mdm2_r <= wb[2:0];
            end
            if (is_addr(s_axi_awaddr, rsq_pkg::A_PKT1)) begin
                app_en_r <= wb[rsq_pkg::APP_BIT];
            end
            if (is_addr(s_axi_awaddr, rsq_pkg::A_AGC0)) begin
                flen_r <= wb[1:0];
            end
            if (is_addr(s_axi_awaddr, rsq_pkg::A_AGC1)) begin
                rel_r <= wb[rsq_pkg::REL_LSB +: 2];
                absoff_r <= wb[3:0];
            end
            if (is_addr(s_axi_awaddr, rsq_pkg::A_AGC2)) begin
                dvga_r <= wb[rsq_pkg::DVGA_LSB +: 2];
                lna_r <= wb[rsq_pkg::LNA_LSB +: 3];
                magn_r <= wb[2:0];
            end
            if (is_addr(s_axi_awaddr, rsq_pkg::A_PINO)) begin
                pin_sel_r <= wb[5:0];
            end
            if (is_addr(s_axi_awaddr, rsq_pkg::A_IEN)) begin
                irq_en_r <= wb[IW-1:0];
            end
        end
    end

    // ************************************************************
    // rssi sampling and carrier sense
    // ************************************************************
    rsq_rate #(.FLW(2)) u_rate (
        .clk(clk),
        .srst(srst),
        .run(rx_mode),
        .filt_strobe(filt_strobe),
        .filt_len(flen_r),
        .sample_en(sample_en)
    );

    rsq_cs u_cs (
        .clk(clk),
        .srst(srst),
        .run(rx_mode),
        .sample_en(sample_en),
        .valid(rssi_valid_r),
        .rssi(rssi_in),
        .lna(lna_r),
        .dvga(dvga_r),
        .magn(magn_r),
        .abs_off(absoff_r),
        .rel_step(rel_r),
        .cs(cs_int)
    );

    assign rx_entry = rx_mode && !rx_d_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            rx_d_r <= 1'b0;
            rssi_r <= 8'h00;
            rssi_last_r <= 8'h00;
            rssi_valid_r <= 1'b0;
            rssi_hold_r <= 1'b0;
        end else begin
            rx_d_r <= rx_mode;
            if (rx_entry) begin
                rssi_valid_r <= 1'b0;
            end else if (rx_mode && sample_en) begin
                rssi_valid_r <= 1'b1;
            end
            // freeze lasts past packet end, up to the next rx entry
            if (rx_entry) begin
                rssi_hold_r <= 1'b0;
            end else if (hold_set) begin
                rssi_hold_r <= 1'b1;
            end
            if (rx_mode && sample_en && !rssi_hold_r) begin
                rssi_r <= rssi_in;
            end
            if (rx_mode && sample_en) begin
                rssi_last_r <= rssi_in;
            end
        end
    end

    // ************************************************************
    // sync qualifier and fifo gating
    // ************************************************************
    assign hit = sync_hit(mdm2_r[1:0], bit_strobe, sync_err16, sync_err32);
    assign sync_clr = !rx_mode || rx_entry || packet_end;
    assign sync_set = !sync_clr && !sync_found && hit
        && (!mdm2_r[2] || cs_int);
    // modes without a sync search never freeze rssi
    assign hold_set = sync_set && (mdm2_r[1:0] != rsq_pkg::SM_NONE);

    always_ff @(posedge clk) begin
        if (srst) begin
            sync_found <= 1'b0;
            filter_en <= 1'b0;
            fifo_wr_en <= 1'b0;
            fifo_wr_data <= 8'h00;
            app_pend_r <= 1'b0;
        end else begin
            if (sync_clr) begin
                sync_found <= 1'b0;
            end else if (sync_set) begin
                sync_found <= 1'b1;
            end
            filter_en <= rx_mode && sync_found;
            fifo_wr_en <= rx_mode && ((rx_byte_valid && sync_found)
                || (app_pend_r && !rx_byte_valid));
            fifo_wr_data <= rx_byte_valid ? rx_byte : rssi_last_r;
            if (packet_end && app_en_r && rx_mode) begin
                app_pend_r <= 1'b1;
            end else if (!rx_byte_valid || !rx_mode) begin
                app_pend_r <= 1'b0;
            end
        end
    end

    // ************************************************************
    // carrier sense outputs and interrupts
    // ************************************************************
    assign irq_ev = {cs_cca && !cs_int, cs_int && !cs_cca, sync_set};
    assign irq_clr = (wr_do && s_axi_wstrb[0]
        && is_addr(s_axi_awaddr, rsq_pkg::A_ICLR)) ? wb[IW-1:0] : '0;
    // a new event wins over a clear in the same cycle
    assign irq_sts_nxt = (irq_sts_r & ~irq_clr) | irq_ev;

    always_ff @(posedge clk) begin
        if (srst) begin
            cs_cca <= 1'b0;
            cs_fast_term <= 1'b0;
            general_output_pin <= 1'b0;
            irq_sts_r <= '0;
            irq <= 1'b0;
        end else begin
            cs_cca <= cs_int;
            cs_fast_term <= cs_int;
            general_output_pin <= (pin_sel_r == rsq_pkg::CS_PIN_SEL)
                && cs_int;
            irq_sts_r <= irq_sts_nxt;
            irq <= |(irq_sts_r & irq_en_r);
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    AST_NONE_SYNC: assert property (
        (rx_mode && rx_d_r && !packet_end && mdm2_r == 3'h0)
        |=> sync_found)
        else $error("mode none did not flag sync");
    AST_CS_GATE: assert property (
        (mdm2_r[2] && !cs_int && !sync_found) |=> !sync_found)
        else $error("sync found without carrier sense");
    AST_NO_WR: assert property (
        (rx_byte_valid && !sync_found) |=> !fifo_wr_en)
        else $error("fifo written before sync");
    AST_FROZEN: assert property (
        rssi_hold_r |=> $stable(rssi_r))
        else $error("rssi moved after sync");
    AST_TRACK: assert property (
        (rx_mode && sample_en && !rssi_hold_r)
        |=> rssi_r == $past(rssi_in))
        else $error("rssi did not track");
    AST_APPEND: assert property (
        (packet_end && app_en_r && rx_mode && !rx_byte_valid)
        |=> ##1 fifo_wr_en)
        else $error("status byte not appended");
    AST_PIN: assert property (
        (pin_sel_r == rsq_pkg::CS_PIN_SEL)
        |=> general_output_pin == $past(cs_int))
        else $error("pin does not follow cs");
    AST_FANOUT: assert property (
        cs_cca == cs_fast_term && cs_cca == $past(cs_int))
        else $error("cs copies disagree");
    AST_IDLE: assert property (
        (!rx_mode && !$past(rx_mode)) |=> !cs_int && $stable(rssi_r))
        else $error("cs or rssi active outside rx");
    AST_IRQ: assert property (
        (|(irq_sts_r & irq_en_r)) |=> irq)
        else $error("interrupt not raised");

    COV_SYNC: cover property (rx_mode ##1 sync_found ##1 fifo_wr_en);
    COV_CS: cover property (!cs_cca ##1 cs_cca ##[1:50] sync_found);
    COV_APP: cover property (packet_end ##[1:4] fifo_wr_en);
endmodule

//--- dv/rsq_demod_model.sv
`timescale 1ns/1ps
module rsq_demod_model (
    input wire logic clk,
    input wire logic rx_mode,
    input wire logic [7:0] level,
    output logic filt_strobe = 1'b0,
    output logic [7:0] rssi_in = 8'h00
);
    // ************************************************************
    // filter samples every cycle while receiving
    // ************************************************************
    // outside receive the estimate is stale, so it toggles
    always @(posedge clk) begin
        filt_strobe <= rx_mode;
        rssi_in <= rx_mode ? level : ~rssi_in;
    end
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("[ERR] %s exp %h got %h", nm, exp, got); \
    end \
end
module testbench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, rx_byte = 8'h00;
    logic [7:0] level = 8'h10, rssi_in, fifo_wr_data, last_byte;
    logic [31:0] wdata = 32'h0000_0000, rdata, rd_d;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, rx_mode = 1'b0, bit_strobe = 1'b0;
    logic rx_byte_valid = 1'b0, packet_end = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, filt_strobe;
    logic sync_found, fifo_wr_en, cs_cca, cs_fast_term, pin, irq, filter_en;
    logic [4:0] err16 = 5'h00;
    logic [5:0] err32 = 6'h00;
    logic [1:0] bresp, rresp, rd_r, wr_b;
    int err_total = 0, comparisons = 0, nwr = 0;
    // mode, mismatches of 16, mismatches of 32, sync expected
    logic [15:0] tbl [0:6] = '{16'h1200, 16'h1101, 16'h2100, 16'h2001,
        16'h3030, 16'h3021, 16'h6001};

    rsq_demod_model model (.clk(clk), .rx_mode(rx_mode), .level(level),
        .filt_strobe(filt_strobe), .rssi_in(rssi_in));
    rsq_top dut (.clk(clk), .srst(srst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rx_mode(rx_mode),
        .filt_strobe(filt_strobe), .rssi_in(rssi_in),
        .bit_strobe(bit_strobe), .sync_err16(err16), .sync_err32(err32),
        .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
        .packet_end(packet_end), .sync_found(sync_found),
        .filter_en(filter_en), .fifo_wr_en(fifo_wr_en),
        .fifo_wr_data(fifo_wr_data),
        .cs_cca(cs_cca), .cs_fast_term(cs_fast_term),
        .general_output_pin(pin), .irq(irq));

    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (fifo_wr_en === 1'b1) begin
            nwr++;
            last_byte <= fifo_wr_data;
        end
    end

    // ************************************************************
    // bus cycles and strobes
    // ************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        wr_b = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd_d = rdata;
        rd_r = rresp;
        rready <= 1'b0;
    endtask
    task automatic pulse(input int k, input logic [7:0] b);
        rx_byte <= b;
        bit_strobe <= (k == 0);
        rx_byte_valid <= (k == 1);
        packet_end <= (k == 2);
        @(posedge clk);
        bit_strobe <= 1'b0;
        rx_byte_valid <= 1'b0;
        packet_end <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic complete_run();
        if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        complete_run();
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rd(rsq_pkg::A_MDM2);
        `CHK("mdm2", 32'h0000_0002, rd_d)
        rd(rsq_pkg::A_AGC1);
        `CHK("agc1", 32'h0000_0000, rd_d)
        rd(rsq_pkg::A_PINO);
        `CHK("pino", 32'h0000_002e, rd_d)
        rd(8'h3c);
        `CHK("unmapped", 2'h2, rd_r)
        wr(8'h3c, 32'h0000_0001);
        `CHK("unmapped_wr", 2'h2, wr_b)
        wr(rsq_pkg::A_PINO, 32'h0000_000e);
        `CHK("okay_wr", 2'h0, wr_b)
        wr(rsq_pkg::A_PKT1, 32'h0000_0004);
        wr(rsq_pkg::A_IEN, 32'h0000_0007);
        rx_mode <= 1'b1;
        repeat (40) @(posedge clk);
        rd(rsq_pkg::A_RSSI);
        `CHK("rssi", 32'h0000_0010, rd_d)
        `CHK("pin", 1'b1, pin)
        `CHK("cca", 1'b1, cs_cca)
        `CHK("fast", 1'b1, cs_fast_term)
        pulse(1, 8'h3c);
        `CHK("nosync_wr", 0, nwr)
        foreach (tbl[i]) begin
            wr(rsq_pkg::A_MDM2, 32'(tbl[i][14:12]));
            err16 <= 5'(tbl[i][11:8]);
            err32 <= 6'(tbl[i][7:4]);
            pulse(0, 8'h00);
            `CHK("sync", tbl[i][0], sync_found)
            `CHK("filter", tbl[i][0], filter_en)
            if (tbl[i][0]) begin
                pulse(1, 8'h5a);
                `CHK("byte", 8'h5a, last_byte)
                pulse(2, 8'h00);
                `CHK("status", 8'h10, last_byte)
            end
        end
        level <= 8'h20;
        repeat (40) @(posedge clk);
        rd(rsq_pkg::A_RSSI);
        `CHK("frozen", 32'h0000_0010, rd_d)
        `CHK("irq", 1'b1, irq)
        rx_mode <= 1'b0;
        level <= 8'ha0;
        repeat (4) @(posedge clk);
        `CHK("cs_idle", 1'b0, cs_cca)
        wr(rsq_pkg::A_ICLR, 32'h0000_0007);
        repeat (2) @(posedge clk);
        `CHK("irq_clr", 1'b0, irq)
        rx_mode <= 1'b1;
        repeat (40) @(posedge clk);
        rd(rsq_pkg::A_RSSI);
        `CHK("rssi_neg", 32'h0000_00a0, rd_d)
        `CHK("cs_low", 1'b0, cs_cca)
        wr(rsq_pkg::A_MDM2, 32'h0000_0005);
        err16 <= 5'h00;
        pulse(0, 8'h00);
        `CHK("gated", 1'b0, sync_found)
        wr(rsq_pkg::A_IEN, 32'h0000_0000);
        level <= 8'h10;
        repeat (40) @(posedge clk);
        `CHK("cs_high", 1'b1, pin)
        `CHK("irq_mask", 1'b0, irq)
        rd(rsq_pkg::A_ISTS);
        `CHK("ists_rise", 1'b1, rd_d[1])
        wr(rsq_pkg::A_MDM2, 32'h0000_0000);
        level <= 8'h30;
        repeat (40) @(posedge clk);
        `CHK("sync_none", 1'b1, sync_found)
        rd(rsq_pkg::A_RSSI);
        `CHK("rssi_none", 32'h0000_0030, rd_d)
        complete_run();
    end
endmodule
